// ==== logic/eeprom_guard_map.svh ====
// constants for the serial eeprom pin interface and write guard
`ifndef EEPROM_GUARD_MAP_SVH
`define EEPROM_GUARD_MAP_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      100
`define GLITCH_NS          100
// least time rounds up to whole cycles
`define GLITCH_CYC         ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INTERNAL_WRITE_CYCLE_TIME_MS 5
// longest time rounds down
`define TWR_CYC            ((`INTERNAL_WRITE_CYCLE_TIME_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// device address word fields
// ----------------------------------------------------------------------------
`define DEV_CODE_MEM       4'ha
`define DEV_CODE_PROT      4'h6
`define DEV_CODE_POS       7
`define DEV_SEL_POS        3
`define DEV_RW_POS         0

// ----------------------------------------------------------------------------
// protection register commands (word address of a 0110 write)
// ----------------------------------------------------------------------------
`define PROT_CMD_SET_REV   8'h00
`define PROT_CMD_SET_PERM  8'h01
`define PROT_CMD_CLR_REV   8'h02
`define PROT_RESET         1'b0

// ----------------------------------------------------------------------------
// array layout
// ----------------------------------------------------------------------------
`define ARRAY_WORDS        256
`define HALF_BIT_POS       7
`define PAGE_BITS          4
`define FIFO_WORDS         8

`endif

// ==== logic/eeprom_guard_pkg.sv ====
// types shared by the serial eeprom design files
package eeprom_guard_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DEVADR  = 3'b001,
    ST_WORDADR = 3'b010,
    ST_WDATA   = 3'b011,
    ST_ACK     = 3'b100,
    ST_RDATA   = 3'b101,
    ST_RACK    = 3'b110
  } link_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ==== logic/write_fifo.sv ====
// small synchronous fifo holding pending array writes
module write_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------------
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("write_fifo needs a power of two depth of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // honest flags straight from the fill count; the count is one bit wider than a pointer
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset, contents are only read when counted valid
  always_ff @(posedge clk) begin
    if (push) mem_r[wr_ptr_r] <= in_data;
  end

endmodule

// ==== logic/serial_eeprom_pin_write_guard.sv ====
// two-wire serial eeprom slave with write-protect gating
//
// Summary of operation
// R1: sample data on serial clock rise, change driven data after its fall.
// R2: data pin only pulled low or released, never driven high.
// R3: three address-select inputs let eight devices share one bus.
// R4: write-protect pin high blocks all array writes; reads still served.
// R5: pin low and no protection programmed: whole array readable and writable.
// R6: pin low and either protection register programmed: lower half write-blocked.
// R7: master keeps serial clock at or below 400 or 1000 kHz.
// R8: glitches shorter than 100 ns on clock and data are ignored.
// R9: data fall with clock high is start, data rise is stop.
// R10: eight-bit words, each received word acknowledged low in ninth clock; the code leaves locked or no-room data bytes unacknowledged.
// R11: answer only to code 1010 or 0110 plus matching select bits.
// R12: internal write cycle begins at stop ending a write, master waits.
// R13: protected bytes stay unchanged and start no internal write cycle.
`include "eeprom_guard_map.svh"

module serial_eeprom_pin_write_guard #(
  parameter int TWR_CYCLES = `TWR_CYC,
  parameter int FILT_CYC   = `GLITCH_CYC,
  parameter int FIFO_DEPTH = `FIFO_WORDS
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic write_protect,
  input  wire logic addr_select_bit0,
  input  wire logic addr_select_bit1,
  input  wire logic addr_select_bit2,
  output logic      write_busy
);

  // ----------------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------------
  generate
    if (TWR_CYCLES < 1 || FILT_CYC < 1 || FILT_CYC > 255) begin : g_bad
      $error("write cycle and filter counts must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // pin synchronisers: three stages, change taken once stages two and three agree
  // ----------------------------------------------------------------------------
  localparam int NPIN = 6;
  wire  [NPIN-1:0] pin_raw = {addr_select_bit2, addr_select_bit1, addr_select_bit0,
                              write_protect, sda_in, scl};
  logic [NPIN-1:0] s1_r, s2_r, s3_r, lvl_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // each pin holds its level until the new one has stood FILT_CYC cycles
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_filt
      logic [7:0] cnt_r;
      wire        moved = (s2_r[gi] == s3_r[gi]) && (s3_r[gi] != lvl_r[gi]);
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cnt_r     <= 8'h00;
          lvl_r[gi] <= 1'b1;
        end else if (!moved) begin
          cnt_r <= 8'h00;
        end else if (cnt_r >= 8'(FILT_CYC - 1)) begin
          cnt_r     <= 8'h00;
          lvl_r[gi] <= s3_r[gi]; // R8
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  endgenerate

  wire       scl_f = lvl_r[0];
  wire       sda_f = lvl_r[1];
  wire       wp_f  = lvl_r[2];
  wire [2:0] sel_f = lvl_r[5:3]; // R3

  // ----------------------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------------------
  logic scl_p_r, sda_p_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl_f;
      sda_p_r <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_p_r;
  wire scl_fall = ~scl_f & scl_p_r;
  wire cond_start = scl_f & scl_p_r & sda_p_r & ~sda_f; // R9
  wire cond_stop  = scl_f & scl_p_r & ~sda_p_r & sda_f; // R9

  // ----------------------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------------------
  eeprom_guard_pkg::link_state_e state_r, state_nxt, after_r, after_nxt;
  logic [3:0]                  cnt_r, cnt_nxt;
  eeprom_guard_pkg::byte_t     sh_r, sh_nxt, ptr_r, ptr_nxt, pcmd_r, pcmd_nxt;
  logic                        oe_r, oe_nxt;
  logic                        pmode_r, pmode_nxt;
  logic                        wr_pend_r, wr_pend_nxt, p_pend_r, p_pend_nxt;
  logic                        perm_r, rev_r, busy_r;
  logic [31:0]                 twr_cnt_r;
  logic                        push, start_wc;
  eeprom_guard_pkg::byte_t     mem_r [`ARRAY_WORDS];

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;

  // protection decode: pin covers all, software registers the lower half
  wire half_lock = perm_r | rev_r;
  wire ptr_locked = wp_f | (half_lock & ~ptr_r[`HALF_BIT_POS]); // R4 R5 R6
  wire [3:0] dev_code = sh_r[`DEV_CODE_POS -: 4];
  wire dev_hit_mem  = (dev_code == `DEV_CODE_MEM);
  wire dev_hit_prot = (dev_code == `DEV_CODE_PROT) & ~sh_r[`DEV_RW_POS];
  wire dev_sel_ok   = (sh_r[`DEV_SEL_POS -: 3] == sel_f);
  // a busy device ignores its address so the master can poll for completion
  wire dev_ack      = (dev_hit_mem | dev_hit_prot) & dev_sel_ok & ~busy_r; // R11 R12
  wire wr_ok        = ~ptr_locked & fifo_in_ready;
  wire [7:0] ptr_page_inc = {ptr_r[7:`PAGE_BITS], ptr_r[`PAGE_BITS-1:0] + 4'h1};
  wire [7:0] rd_byte  = mem_r[ptr_r];

  // ----------------------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    after_nxt   = after_r;
    cnt_nxt     = cnt_r;
    sh_nxt      = sh_r;
    ptr_nxt     = ptr_r;
    pcmd_nxt    = pcmd_r;
    oe_nxt      = oe_r;
    pmode_nxt   = pmode_r;
    wr_pend_nxt = wr_pend_r;
    p_pend_nxt  = p_pend_r;
    push        = 1'b0;
    start_wc    = 1'b0;
    if (cond_start) begin
      state_nxt = eeprom_guard_pkg::ST_DEVADR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else if (cond_stop) begin
      state_nxt   = eeprom_guard_pkg::ST_IDLE;
      oe_nxt      = 1'b0;
      start_wc    = wr_pend_r | p_pend_r; // R12 R13
      wr_pend_nxt = 1'b0;
      p_pend_nxt  = 1'b0;
    end else begin
      case (state_r)
        eeprom_guard_pkg::ST_DEVADR,
        eeprom_guard_pkg::ST_WORDADR,
        eeprom_guard_pkg::ST_WDATA: begin
          if (scl_rise && cnt_r < 4'h8) begin
            sh_nxt  = {sh_r[6:0], sda_f}; // R1
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_nxt   = 4'h0;
            state_nxt = eeprom_guard_pkg::ST_ACK;
            if (state_r == eeprom_guard_pkg::ST_DEVADR) begin
              oe_nxt    = dev_ack; // R10 R11
              pmode_nxt = dev_hit_prot;
              after_nxt = sh_r[`DEV_RW_POS] ? eeprom_guard_pkg::ST_RDATA : eeprom_guard_pkg::ST_WORDADR;
              if (!dev_ack) state_nxt = eeprom_guard_pkg::ST_IDLE;
            end else if (state_r == eeprom_guard_pkg::ST_WORDADR) begin
              oe_nxt    = 1'b1; // R10
              after_nxt = eeprom_guard_pkg::ST_WDATA;
              if (pmode_r) pcmd_nxt = sh_r;
              else         ptr_nxt  = sh_r;
            end else if (pmode_r) begin
              oe_nxt     = 1'b1;
              after_nxt  = eeprom_guard_pkg::ST_WDATA;
              p_pend_nxt = 1'b1;
            end else begin
              // locked or no room: refuse the byte, leave array untouched
              oe_nxt      = wr_ok; // R13
              push        = wr_ok;
              wr_pend_nxt = wr_pend_r | wr_ok;
              ptr_nxt     = wr_ok ? ptr_page_inc : ptr_r;
              after_nxt   = eeprom_guard_pkg::ST_WDATA;
              if (!wr_ok) state_nxt = eeprom_guard_pkg::ST_IDLE;
            end
          end
        end
        eeprom_guard_pkg::ST_ACK: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0; // R2
            state_nxt = after_r;
            if (after_r == eeprom_guard_pkg::ST_RDATA) begin
              sh_nxt  = rd_byte;
              oe_nxt  = ~rd_byte[7]; // R1 R2
              cnt_nxt = 4'h1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        eeprom_guard_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              oe_nxt    = 1'b0;
              state_nxt = eeprom_guard_pkg::ST_RACK;
            end else begin
              oe_nxt  = ~sh_r[6]; // R1 R2
              sh_nxt  = {sh_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        eeprom_guard_pkg::ST_RACK: begin
          // master acknowledge asks for the next byte, a high level ends the read
          if (scl_rise) begin
            state_nxt = sda_f ? eeprom_guard_pkg::ST_IDLE : eeprom_guard_pkg::ST_ACK;
            after_nxt = eeprom_guard_pkg::ST_RDATA;
          end
        end
        default: state_nxt = eeprom_guard_pkg::ST_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r   <= eeprom_guard_pkg::ST_IDLE;
      after_r   <= eeprom_guard_pkg::ST_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      ptr_r     <= 8'h00;
      pcmd_r    <= 8'h00;
      oe_r      <= 1'b0;
      pmode_r   <= 1'b0;
      wr_pend_r <= 1'b0;
      p_pend_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      after_r   <= after_nxt;
      cnt_r     <= cnt_nxt;
      sh_r      <= sh_nxt;
      ptr_r     <= ptr_nxt;
      pcmd_r    <= pcmd_nxt;
      oe_r      <= oe_nxt;
      pmode_r   <= pmode_nxt;
      wr_pend_r <= wr_pend_nxt;
      p_pend_r  <= p_pend_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // internal write cycle and protection registers
  // ----------------------------------------------------------------------------
  // the permanent lock is cleared only by reset; reversible clear is void once locked
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_r    <= 1'b0;
      twr_cnt_r <= 32'h0000_0000;
      perm_r    <= `PROT_RESET;
      rev_r     <= `PROT_RESET;
    end else if (start_wc) begin
      busy_r    <= 1'b1; // R12
      twr_cnt_r <= 32'(TWR_CYCLES - 1);
      if (p_pend_r && !wp_f) begin
        if (pcmd_r == `PROT_CMD_SET_PERM) perm_r <= 1'b1;
        if (pcmd_r == `PROT_CMD_SET_REV)  rev_r  <= 1'b1;
        if (pcmd_r == `PROT_CMD_CLR_REV && !perm_r) rev_r <= 1'b0;
      end
    end else if (busy_r) begin
      if (twr_cnt_r == 32'h0000_0000) busy_r <= 1'b0;
      else                            twr_cnt_r <= twr_cnt_r - 32'h0000_0001;
    end
  end

  // array written only while the cycle runs, so the fifo holds the bytes until the stop and drains meanwhile
  always_ff @(posedge clk) begin
    if (busy_r && fifo_out_valid) mem_r[fifo_out_data[15:8]] <= fifo_out_data[7:0]; // R13
  end

  write_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr_r, sh_r}),
    .out_valid (fifo_out_valid),
    .out_ready (busy_r),
    .out_data  (fifo_out_data)
  );

  // open drain: the output level is always low, only the enable moves
  assign sda_out    = 1'b0; // R2
  assign sda_oe     = oe_r;
  assign write_busy = busy_r;

endmodule

// ==== verification/eeprom_guard_monitor.sv ====
// assertion checker for the serial eeprom pin interface
module eeprom_guard_monitor #(
  parameter int TWR_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // pin history
  // ------------------------------------------------------------
  logic        scl_r, sda_r, frame_r;
  logic [3:0]  fall_cnt_r, stop_cnt_r;
  logic [31:0] busy_cnt_r;
  // raw pin view: conditions are seen before the device's synchroniser
  wire         start_seen   = scl && scl_r && sda_r && !sda_in;
  wire         stop_seen    = scl && scl_r && !sda_r && sda_in;
  wire [3:0]   fall_cnt_nxt = (scl_r && !scl) ? 4'h0 : fall_cnt_r + {3'h0, fall_cnt_r != 4'hf};
  wire [3:0]   stop_cnt_nxt = stop_seen ? 4'h0 : stop_cnt_r + {3'h0, stop_cnt_r != 4'hf};
  wire         frame_nxt    = start_seen || (frame_r && !stop_seen);
  wire [31:0]  busy_cnt_nxt = write_busy ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;

  // the fall and stop counters saturate so a long idle never wraps into a false match
  always_ff @(posedge clk) begin
    scl_r      <= rst_b ? scl : 1'b1;
    sda_r      <= rst_b ? sda_in : 1'b1;
    fall_cnt_r <= rst_b ? fall_cnt_nxt : 4'hf;
    stop_cnt_r <= rst_b ? stop_cnt_nxt : 4'hf;
    frame_r    <= rst_b && frame_nxt;
    busy_cnt_r <= rst_b ? busy_cnt_nxt : 32'h0000_0000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !sda_oe && !write_busy)
    else $error("outputs active after reset edge");
  chk_never_high: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  chk_answer_time: assert property ($changed(sda_oe) |-> fall_cnt_r <= 4'h9)
    else $error("data pin changed away from a clock fall");
  chk_ack_stands: assert property (sda_oe && $rose(scl) |=> sda_oe [*2])
    else $error("low level dropped during clock high");
  chk_drive_in_frame: assert property ($rose(sda_oe) |-> frame_r)
    else $error("device drove data outside a frame");
  chk_busy_after_stop: assert property ($rose(write_busy) |-> stop_cnt_r <= 4'h8)
    else $error("write cycle began without a stop");
  chk_wp_blocks: assert property ($rose(write_busy) |-> !$past(write_protect, 6))
    else $error("write cycle while write protect high");
  chk_busy_length: assert property ($fell(write_busy) |->
    busy_cnt_r >= TWR_CYCLES && busy_cnt_r <= TWR_CYCLES + 1)
    else $error("write cycle length wrong");

  cover property ($rose(write_busy));
  cover property (sda_oe && $rose(scl));
  cover property ($fell(write_busy));
endmodule

// ==== verification/bus_master.sv ====
// behavioural two-wire bus master driving the serial pins
module bus_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // pin sequencing, clock stands high between frames
  // ------------------------------------------------------------
  int stretch = 0; // extra low cycles make a slow master
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // wait n system clocks, then step just off the edge
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one 800 ns clock pulse: six clocks low, since the device answers about
  // five clocks after a fall and must settle before the rise, then two high
  task automatic bit_x(input logic b, output logic r);
    q(2);
    sda_pull = !b;
    q(4 + stretch);
    scl = 1'b1;
    q(1);
    r = sda_line;
    q(1);
    scl = 1'b0;
  endtask
  // the clock rises only after a pending acknowledge has been released
  task automatic start();
    q(2);
    sda_pull = 1'b0;
    q(4);
    scl = 1'b1;
    q(3);
    sda_pull = 1'b1;
    q(3);
    scl = 1'b0;
  endtask
  task automatic stop();
    q(2);
    sda_pull = 1'b1;
    q(4);
    scl = 1'b1;
    q(3);
    sda_pull = 1'b0;
    q(4);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!more, r);
  endtask
endmodule

// ==== verification/test_serial_eeprom_pin_write_guard.sv ====
// self-checking bench for the serial eeprom pin interface and write guard
module test_serial_eeprom_pin_write_guard;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int INTERNAL_WRITE_CYCLE_TIME = 200;
  typedef struct packed {
    logic [7:0] cmd; // protection command sent first, 8'hff for none
    logic       wp;
    logic [7:0] wa;
    logic [7:0] wd;
    logic       ack;
    logic [7:0] rd;
  } row_s;
  row_s rows [9] = '{'{8'hff, 1'b0, 8'h10, 8'h11, 1'b1, 8'h11}, '{8'hff, 1'b0, 8'h90, 8'h22, 1'b1, 8'h22},
    '{8'hff, 1'b1, 8'h10, 8'h33, 1'b0, 8'h11}, '{8'hff, 1'b1, 8'h90, 8'h44, 1'b0, 8'h22},
    '{8'h00, 1'b0, 8'h10, 8'h55, 1'b0, 8'h11}, '{8'hff, 1'b0, 8'h80, 8'h66, 1'b1, 8'h66},
    '{8'h02, 1'b0, 8'h7f, 8'h77, 1'b1, 8'h77}, '{8'h01, 1'b0, 8'h7f, 8'h88, 1'b0, 8'h77},
    '{8'h02, 1'b0, 8'h10, 8'h99, 1'b0, 8'h11}};
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       write_protect = 1'b0;
  logic [2:0] sel = 3'h5;
  logic       scl, sda_pull, sda_out, sda_oe, write_busy, a;
  // wired line with pull-up: low when either side pulls
  wire        sda_line = !(sda_pull || (sda_oe && !sda_out));
  int         n_mismatch = 0;
  int         checks_done = 0;
  always #50 clk = ~clk;

  serial_eeprom_pin_write_guard #(.TWR_CYCLES(INTERNAL_WRITE_CYCLE_TIME)) i_serial_eeprom_pin_write_guard (.clk(clk), .rst_b(rst_b),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .write_busy(write_busy));
  bus_master i_bus_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for the internal write cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    // the stop reaches the write cycle a few clocks late through the synchroniser
    i_bus_master.q(8);
    while (write_busy !== 1'b0) begin
      i_bus_master.q(1);
      n++;
      if (n > 3 * INTERNAL_WRITE_CYCLE_TIME) begin
        n_mismatch++;
        $display("wrong value at %0t: write cycle never ended", $time);
        test_done();
      end
    end
  endtask
  task automatic xfer(input logic [3:0] code, input logic [7:0] wa, input logic [7:0] wd, output logic ack);
    i_bus_master.start();
    i_bus_master.wr({code, sel, 1'b0}, ack);
    if (ack) i_bus_master.wr(wa, ack);
    if (ack) i_bus_master.wr(wd, ack);
    i_bus_master.stop();
  endtask
  // random read of n bytes, expecting e, e+1, ...
  task automatic rdchk(input logic [7:0] wa, input int n, input logic [7:0] e);
    logic       k;
    logic [7:0] d;
    i_bus_master.start();
    i_bus_master.wr({4'ha, sel, 1'b0}, k);
    i_bus_master.wr(wa, k);
    i_bus_master.start();
    i_bus_master.wr({4'ha, sel, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      i_bus_master.rd(i < n - 1, d);
      check(d, e + 8'(i));
    end
    i_bus_master.stop();
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    check({6'h00, sda_oe, write_busy}, 8'h00);
    rst_b = 1'b1;
    i_bus_master.q(8);
    foreach (rows[i]) begin
      write_protect = rows[i].wp;
      if (rows[i].cmd != 8'hff) begin
        xfer(4'h6, rows[i].cmd, 8'h00, a);
        check({7'h00, a}, 8'h01);
        wait_idle();
      end
      xfer(4'ha, rows[i].wa, rows[i].wd, a);
      check({7'h00, a}, {7'h00, rows[i].ack});
      i_bus_master.q(10);
      check({7'h00, write_busy}, {7'h00, rows[i].ack});
      wait_idle();
      rdchk(rows[i].wa, 1, rows[i].rd);
    end
    // only the matching select value is answered, with a slow master
    i_bus_master.stretch = 2;
    for (int s = 0; s < 8; s++) begin
      i_bus_master.start();
      i_bus_master.wr({4'ha, 3'(s), 1'b0}, a);
      i_bus_master.stop();
      check({7'h00, a}, {7'h00, 3'(s) == sel});
    end
    i_bus_master.stretch = 0;
    // fill the write buffer until it refuses the ninth byte
    i_bus_master.start();
    i_bus_master.wr({4'ha, sel, 1'b0}, a);
    i_bus_master.wr(8'hc0, a);
    for (int i = 0; i < 9; i++) begin
      i_bus_master.wr(8'hc0 + 8'(i), a);
      check({7'h00, a}, {7'h00, i < 8});
    end
    i_bus_master.stop();
    // an address during the write cycle is refused
    i_bus_master.start();
    i_bus_master.wr({4'ha, sel, 1'b0}, a);
    i_bus_master.stop();
    check({7'h00, a}, 8'h00);
    wait_idle();
    rdchk(8'hc0, 8, 8'hc0);
    // mid-run reset: outputs quiet, both software locks cleared, lower half writable again
    rst_b = 1'b0;
    i_bus_master.q(12);
    check({6'h00, sda_oe, write_busy}, 8'h00);
    rst_b = 1'b1;
    i_bus_master.q(8);
    xfer(4'ha, 8'h20, 8'h5a, a);
    check({7'h00, a}, 8'h01);
    wait_idle();
    rdchk(8'h20, 1, 8'h5a);
    test_done();
  end
endmodule

bind serial_eeprom_pin_write_guard eeprom_guard_monitor #(.TWR_CYCLES(TWR_CYCLES)) i_eeprom_guard_monitor (
  .clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect(write_protect), .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
  .addr_select_bit2(addr_select_bit2), .write_busy(write_busy));
